//--- core/rsic_top.sv
// status flags, interrupt merge and divider reset of the clock chip
`timescale 1ns/1ns
module rsic_top
  import rsic_pkg::*;
#(
  parameter logic [rsic_pkg::CNT_W-1:0] RTN_CYC_P =
    rsic_pkg::CNT_W'(rsic_pkg::RTN_CYC),
  parameter logic [rsic_pkg::CNT_W-1:0] OSC_CYC_P =
    rsic_pkg::CNT_W'(rsic_pkg::OSC_CYC),
  parameter logic [rsic_pkg::CNT_W-1:0] SUP_CYC_P =
    rsic_pkg::CNT_W'(rsic_pkg::SUP_CYC),
  parameter logic [rsic_pkg::CNT_W-1:0] HALF_CYC_P =
    rsic_pkg::CNT_W'(rsic_pkg::HALF_CYC)
) (
  input  wire logic                        i_mclk,
  input  wire logic                        i_rst_n,
  input  wire logic                        i_wr_en,
  input  wire logic                        i_rd_en,
  input  wire logic [rsic_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [rsic_pkg::DATA_W-1:0] i_wdata,
  output logic      [rsic_pkg::DATA_W-1:0] o_rdata,
  input  wire logic                        i_bus_stop,
  input  wire logic                        i_bus_restart,
  input  wire logic                        i_update_evt,
  input  wire logic                        i_timer_evt,
  input  wire logic                        i_alarm_evt,
  input  wire logic                        i_below_clock_hold,
  input  wire logic                        i_below_comp_level,
  input  wire logic                        i_osc_stopped,
  output logic                             o_irq_n_out,
  output logic                             o_irq_n_oe,
  output logic                             o_chain_clr,
  output logic                             o_sec_tick,
  output logic                             o_comp_sample,
  output logic                             o_comp_halted
);
  logic       wr_flags;
  logic       wr_ctrl;
  logic       rd_flags;
  logic       rd_ctrl;
  logic       update_event_flag_q;
  logic       timer_event_flag_q;
  logic       alarm_event_flag_q;
  logic       voltage_low_flag_q;
  logic       comp_voltage_flag_q;
  logic [1:0] comp_interval_sel_q;
  logic       update_irq_enable_q;
  logic       timer_irq_enable_q;
  logic       alarm_irq_enable_q;
  logic       divrst_q;
  logic [CNT_W-1:0] sup_cnt_q;
  logic [CNT_W-1:0] osc_cnt_q;
  logic       sup_set;
  logic       osc_set;
  logic       chain_clr_d;
  logic       half_tick;
  logic [HT_W-1:0] ht_cnt_q;
  logic [HT_W-1:0] ht_target;
  logic       comp_instant;
  logic [1:0] auto_evt;
  logic [1:0] auto_en;
  logic [1:0] auto_hold_q;
  logic [DATA_W-1:0] flags_view;
  logic [DATA_W-1:0] ctrl_view;

  // address decode; both printed mirrors reach the same register
  assign wr_flags = i_wr_en & ((i_addr == ADDR_FLAGS) |
                               (i_addr == ADDR_FLAGS_ALT));
  assign wr_ctrl  = i_wr_en & ((i_addr == ADDR_CTRL) |
                               (i_addr == ADDR_CTRL_ALT));
  assign rd_flags = (i_addr == ADDR_FLAGS) | (i_addr == ADDR_FLAGS_ALT);
  assign rd_ctrl  = (i_addr == ADDR_CTRL) | (i_addr == ADDR_CTRL_ALT);

  // supply drop filter: 1 ms below threshold, detector never sleeps
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sup_cnt_q <= '0;
    end else if (!i_below_clock_hold) begin
      sup_cnt_q <= '0;
    end else if (!sup_set) begin
      sup_cnt_q <= sup_cnt_q + CNT_W'(1);
    end
  end
  assign sup_set = i_below_clock_hold & (sup_cnt_q == SUP_CYC_P - CNT_W'(1));

  // oscillator stop watchdog
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      osc_cnt_q <= '0;
    end else if (!i_osc_stopped) begin
      osc_cnt_q <= '0;
    end else if (!osc_set) begin
      osc_cnt_q <= osc_cnt_q + CNT_W'(1);
    end
  end
  assign osc_set = i_osc_stopped & (osc_cnt_q == OSC_CYC_P - CNT_W'(1));

  // event flags: write zero clears, write one ignored, set beats clear
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      update_event_flag_q <= 1'b0;
      timer_event_flag_q  <= 1'b0;
      alarm_event_flag_q  <= 1'b0;
      voltage_low_flag_q  <= 1'b1;
      comp_voltage_flag_q <= 1'b1;
    end else begin
      if (i_update_evt) begin
        update_event_flag_q <= 1'b1;
      end else if (wr_flags && !i_wdata[FLG_UPDATE]) begin
        update_event_flag_q <= 1'b0;
      end
      if (i_timer_evt) begin
        timer_event_flag_q <= 1'b1;
      end else if (wr_flags && !i_wdata[FLG_TIMER]) begin
        timer_event_flag_q <= 1'b0;
      end
      if (i_alarm_evt) begin
        alarm_event_flag_q <= 1'b1;
      end else if (wr_flags && !i_wdata[FLG_ALARM]) begin
        alarm_event_flag_q <= 1'b0;
      end
      if (sup_set || osc_set) begin
        voltage_low_flag_q <= 1'b1;
      end else if (wr_flags && !i_wdata[FLG_VLOW]) begin
        voltage_low_flag_q <= 1'b0;
      end
      if (comp_instant && i_below_comp_level) begin
        comp_voltage_flag_q <= 1'b1;
      end else if (wr_flags && !i_wdata[FLG_VCOMP]) begin
        comp_voltage_flag_q <= 1'b0;
      end
    end
  end

  // control register; divider reset arms here and fires on STOP
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      comp_interval_sel_q <= CTL_RESET[CTL_CSEL_HI:CTL_CSEL_LO];
      update_irq_enable_q <= CTL_RESET[CTL_UIE];
      timer_irq_enable_q  <= CTL_RESET[CTL_TIE];
      alarm_irq_enable_q  <= CTL_RESET[CTL_AIE];
      divrst_q            <= CTL_RESET[CTL_DIVRST];
    end else begin
      if (wr_ctrl) begin
        comp_interval_sel_q <= i_wdata[CTL_CSEL_HI:CTL_CSEL_LO];
        update_irq_enable_q <= i_wdata[CTL_UIE];
        timer_irq_enable_q  <= i_wdata[CTL_TIE];
        alarm_irq_enable_q  <= i_wdata[CTL_AIE];
      end
      // restart leaves it armed, stop fires and clears
      if (wr_ctrl && i_wdata[CTL_DIVRST]) begin
        divrst_q <= 1'b1;
      end else if (i_bus_stop) begin
        divrst_q <= 1'b0;
      end
    end
  end
  assign chain_clr_d = divrst_q & i_bus_stop;

  // one-cycle clear pulse for the prescaler and dependent timers
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_chain_clr <= 1'b0;
    end else begin
      // restarts update, alarm and timer timing
      o_chain_clr <= chain_clr_d;
    end
  end

  // only the divided stages are cleared; i_mclk path untouched
  rsic_prescaler #(
    .HALF_CYC_P (HALF_CYC_P)
  ) u_prescaler (
    .i_mclk      (i_mclk),
    .i_rst_n     (i_rst_n),
    .i_chain_clr (o_chain_clr),
    .o_half_tick (half_tick),
    .o_sec_tick  (o_sec_tick)
  );

  always_comb begin
    unique case (rsic_csel_t'(comp_interval_sel_q))
      RSIC_CSEL_0S5: ht_target = HT_0S5;
      RSIC_CSEL_2S:  ht_target = HT_2S;
      RSIC_CSEL_10S: ht_target = HT_10S;
      RSIC_CSEL_30S: ht_target = HT_30S;
    endcase
  end

  // compensation timer in half seconds; a shortened select takes
  // effect at once rather than waiting out the old period
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ht_cnt_q <= '0;
    end else if (o_chain_clr) begin
      ht_cnt_q <= '0;
    end else if (comp_instant) begin
      ht_cnt_q <= '0;
    end else if (half_tick) begin
      ht_cnt_q <= ht_cnt_q + HT_W'(1);
    end
  end
  assign comp_instant = (ht_cnt_q >= ht_target);

  // halted indication follows the comp flag
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_comp_sample <= 1'b0;
      o_comp_halted <= 1'b1;
    end else begin
      o_comp_sample <= comp_instant;
      o_comp_halted <= comp_voltage_flag_q;
    end
  end

  // auto-release sources: index 0 update, index 1 timer
  assign auto_evt = {i_timer_evt, i_update_evt};
  assign auto_en  = {timer_irq_enable_q, update_irq_enable_q};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_auto
      logic [CNT_W-1:0] rtn_q;
      // hold low at least the release time unless the enable is cleared
      always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          auto_hold_q[gi] <= 1'b0;
          rtn_q           <= '0;
        end else if (auto_evt[gi] && auto_en[gi]) begin
          auto_hold_q[gi] <= 1'b1;
          rtn_q           <= '0;
        end else if (!auto_en[gi]) begin
          auto_hold_q[gi] <= 1'b0;
          rtn_q           <= '0;
        end else if (auto_hold_q[gi]) begin
          if (rtn_q == RTN_CYC_P - CNT_W'(1)) begin
            auto_hold_q[gi] <= 1'b0;
          end else begin
            rtn_q <= rtn_q + CNT_W'(1);
          end
        end
      end
    end
  endgenerate

  assign o_irq_n_oe  = (|(auto_hold_q & auto_en)) |
                       (alarm_irq_enable_q & alarm_event_flag_q);
  assign o_irq_n_out = 1'b0;

  assign flags_view = {2'b00, update_event_flag_q, timer_event_flag_q,
                       alarm_event_flag_q, 1'b0, voltage_low_flag_q,
                       comp_voltage_flag_q};
  assign ctrl_view  = {comp_interval_sel_q, update_irq_enable_q,
                       timer_irq_enable_q, alarm_irq_enable_q, 2'b00,
                       divrst_q} & CTL_WMASK;

  // read data registered; unmapped addresses read zero
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else if (i_rd_en) begin
      o_rdata <= rd_flags ? flags_view : (rd_ctrl ? ctrl_view : '0);
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  sequence s_arm_stop;
    divrst_q && i_bus_stop;
  endsequence
  sequence s_clr_then_idle;
    o_chain_clr ##1 !o_chain_clr;
  endsequence

  property p_vlow_hold;
    voltage_low_flag_q && !(wr_flags && !i_wdata[FLG_VLOW])
      |=> voltage_low_flag_q;
  endproperty
  a_vlow_hold: assert property (p_vlow_hold)
    else $error("voltage-low flag dropped without a zero write");
  property p_sup_set;
    sup_set |=> voltage_low_flag_q;
  endproperty
  a_sup_set: assert property (p_sup_set)
    else $error("supply drop did not set voltage-low");
  property p_comp_set;
    comp_instant && i_below_comp_level |=> comp_voltage_flag_q ##1
      o_comp_halted;
  endproperty
  a_comp_set: assert property (p_comp_set)
    else $error("low supply at compensation not flagged");
  property p_upd_set;
    i_update_evt |=> update_event_flag_q;
  endproperty
  a_upd_set: assert property (p_upd_set)
    else $error("update event lost");
  property p_tmr_w1;
    !timer_event_flag_q && wr_flags && i_wdata[FLG_TIMER] && !i_timer_evt
      |=> !timer_event_flag_q;
  endproperty
  a_tmr_w1: assert property (p_tmr_w1)
    else $error("writing one set the timer flag");
  property p_alarm_irq;
    alarm_irq_enable_q && alarm_event_flag_q |-> o_irq_n_oe;
  endproperty
  a_alarm_irq: assert property (p_alarm_irq)
    else $error("alarm request not driving irq");
  property p_no_enable;
    !update_irq_enable_q && !timer_irq_enable_q && !alarm_irq_enable_q
      |-> !o_irq_n_oe;
  endproperty
  a_no_enable: assert property (p_no_enable)
    else $error("irq driven with all enables off");
  property p_upd_min_low;
    update_irq_enable_q && i_update_evt ##1 update_irq_enable_q[*8]
      |-> o_irq_n_oe;
  endproperty
  a_upd_min_low: assert property (p_upd_min_low)
    else $error("update irq released too early");
  property p_divrst_stop;
    s_arm_stop |=> s_clr_then_idle and (!divrst_q);
  endproperty
  a_divrst_stop: assert property (p_divrst_stop)
    else $error("divider reset did not fire on stop");
  property p_divrst_restart;
    divrst_q && i_bus_restart && !i_bus_stop |=> divrst_q && !o_chain_clr;
  endproperty
  a_divrst_restart: assert property (p_divrst_restart)
    else $error("divider reset fired on restart");
endmodule

//--- core/rsic_pkg.sv
// constants shared by the status and interrupt control block
package rsic_pkg;
  // register access port
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS     = 5'h0E;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS_ALT = 5'h1E;
  localparam logic [ADDR_W-1:0] ADDR_CTRL      = 5'h0F;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_ALT  = 5'h1F;

  // event_flags field positions
  localparam int FLG_UPDATE = 5;
  localparam int FLG_TIMER  = 4;
  localparam int FLG_ALARM  = 3;
  localparam int FLG_VLOW   = 1;
  localparam int FLG_VCOMP  = 0;

  // irq_and_comp_control field positions
  localparam int CTL_CSEL_HI = 7;
  localparam int CTL_CSEL_LO = 6;
  localparam int CTL_UIE     = 5;
  localparam int CTL_TIE     = 4;
  localparam int CTL_AIE     = 3;
  localparam int CTL_DIVRST  = 0;
  localparam logic [DATA_W-1:0] CTL_RESET = 8'h40;
  localparam logic [DATA_W-1:0] CTL_WMASK = 8'hF9;

  // compensation interval, counted in half-second ticks
  typedef enum logic [1:0] {
    RSIC_CSEL_0S5 = 2'b00,
    RSIC_CSEL_2S  = 2'b01,
    RSIC_CSEL_10S = 2'b10,
    RSIC_CSEL_30S = 2'b11
  } rsic_csel_t;
  localparam int HT_W = 7;
  localparam logic [HT_W-1:0] HT_0S5 = 7'h01;
  localparam logic [HT_W-1:0] HT_2S  = 7'h04;
  localparam logic [HT_W-1:0] HT_10S = 7'h14;
  localparam logic [HT_W-1:0] HT_30S = 7'h3C;

  // timing: times in their own unit, cycle counts derived
  localparam int CNT_W       = 26;
  localparam longint CLK_NS  = 20;
  localparam longint RTN_NS  = 7813000;   // least release delay
  localparam longint OSC_NS  = 100000000; // osc stop to flag, longest
  localparam longint SUP_NS  = 1000000;   // supply drop filter, 1 ms
  localparam longint HALF_NS = 500000000; // prescaler half second
  localparam longint RTN_CYC  = (RTN_NS + CLK_NS - 1) / CLK_NS;
  localparam longint OSC_CYC  = OSC_NS / CLK_NS;
  localparam longint SUP_CYC  = (SUP_NS + CLK_NS - 1) / CLK_NS;
  localparam longint HALF_CYC = HALF_NS / CLK_NS;
endpackage

//--- core/rsic_prescaler.sv
// prescaler chain giving half-second and second ticks
`timescale 1ns/1ns
module rsic_prescaler
  import rsic_pkg::*;
#(
  parameter logic [rsic_pkg::CNT_W-1:0] HALF_CYC_P =
    rsic_pkg::CNT_W'(rsic_pkg::HALF_CYC)
) (
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  input  wire logic i_chain_clr,
  output logic      o_half_tick,
  output logic      o_sec_tick
);
  logic [CNT_W-1:0] cyc_q;
  logic             half_q;
  logic             wrap;

  assign wrap = (cyc_q == HALF_CYC_P - CNT_W'(1));

  // cycle divider; a clear restarts a full second from zero
  // full second after clear
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cyc_q  <= '0;
      half_q <= 1'b0;
    end else if (i_chain_clr) begin
      cyc_q  <= '0;
      half_q <= 1'b0;
    end else if (wrap) begin
      cyc_q  <= '0;
      half_q <= ~half_q;
    end else begin
      cyc_q  <= cyc_q + CNT_W'(1);
    end
  end

  // tick outputs registered
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_half_tick <= 1'b0;
      o_sec_tick  <= 1'b0;
    end else begin
      o_half_tick <= wrap & ~i_chain_clr;
      o_sec_tick  <= wrap & half_q & ~i_chain_clr;
    end
  end
endmodule

//--- dv/rsic_host_model.sv
// host controller model driving the register strobe port
`timescale 1ns/1ns
module rsic_host_model
  import rsic_pkg::*;
(
  input  wire logic                        i_mclk,
  input  wire logic [rsic_pkg::DATA_W-1:0] i_rdata,
  output logic                             o_wr_en,
  output logic                             o_rd_en,
  output logic      [rsic_pkg::ADDR_W-1:0] o_addr,
  output logic      [rsic_pkg::DATA_W-1:0] o_wdata,
  output logic                             o_bus_stop,
  output logic                             o_bus_restart
);
  // idle bus: strobes low, data lines toggled so stale values never match
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 5'h00;
    o_wdata = 8'hA5;
    o_bus_stop = 1'b0;
    o_bus_restart = 1'b0;
  end

  // one byte write, strobe held over exactly one rising edge
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge i_mclk);
    o_addr = a;
    o_wdata = d;
    o_wr_en = 1'b1;
    @(negedge i_mclk);
    o_wr_en = 1'b0;
    o_wdata = ~d;
  endtask

  // one byte read; data sampled a cycle and a half after the taking edge
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(negedge i_mclk);
    o_addr = a;
    o_rd_en = 1'b1;
    @(negedge i_mclk);
    o_rd_en = 1'b0;
    @(negedge i_mclk);
    d = i_rdata;
  endtask

  // stop or restart after the byte
  task automatic cond(input logic stop);
    @(negedge i_mclk);
    o_bus_stop = stop;
    o_bus_restart = ~stop;
    @(negedge i_mclk);
    o_bus_stop = 1'b0;
    o_bus_restart = 1'b0;
  endtask

  // reinit after voltage loss, enables left at zero for polling
  task automatic reinit();
    wr(ADDR_FLAGS, 8'h00);
    wr(ADDR_CTRL, CTL_RESET);
  endtask
endmodule

//--- dv/rsic_top_tb.sv
// self-checking bench for the status and interrupt control block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  err_total++; $display("unexpected %s expected %0h seen %0h", nm, e, g); \
  end end
module rsic_top_tb;
  import rsic_pkg::*;
  logic              i_mclk;
  logic              i_rst_n;
  logic [2:0]        evt;
  logic              hold;
  logic              comp;
  logic              osc;
  logic              wr_en, rd_en, stop, rstart, irq_out, irq_oe;
  logic              clr, sec, samp, halted;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, d;
  wire               irq_pin;
  int                err_total = 0;
  int                comparisons = 0;
  int                cyc = 0;
  int                n;

  // open-drain pin with pull-up
  assign irq_pin = irq_oe ? irq_out : 1'b1;

  always #10 i_mclk = ~i_mclk;

  rsic_top #(.RTN_CYC_P(26'd20), .OSC_CYC_P(26'd30), .SUP_CYC_P(26'd5),
    .HALF_CYC_P(26'd10)) u_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata),
    .o_rdata(rdata), .i_bus_stop(stop), .i_bus_restart(rstart),
    .i_update_evt(evt[2]), .i_timer_evt(evt[1]), .i_alarm_evt(evt[0]),
    .i_below_clock_hold(hold), .i_below_comp_level(comp),
    .i_osc_stopped(osc), .o_irq_n_out(irq_out), .o_irq_n_oe(irq_oe),
    .o_chain_clr(clr), .o_sec_tick(sec), .o_comp_sample(samp),
    .o_comp_halted(halted));

  rsic_host_model u_host (.i_mclk(i_mclk), .i_rdata(rdata), .o_wr_en(wr_en),
    .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata), .o_bus_stop(stop),
    .o_bus_restart(rstart));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // hang guard, far above the few thousand cycles the run needs
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic pulse(input logic [2:0] e);
    @(negedge i_mclk);
    evt = e;
    @(negedge i_mclk);
    evt = 3'b000;
  endtask

  task automatic wait_cyc(input int k);
    repeat (k) @(negedge i_mclk);
  endtask

  // negedges until the chosen pulse is seen, capped at 1000
  task automatic gap(input int w, output int k);
    k = 0;
    while (!(w == 0 ? samp : w == 1 ? sec : clr) && k < 1000) begin
      @(negedge i_mclk);
      k++;
    end
  endtask

  task automatic t_reset();
    u_host.rd(ADDR_FLAGS, d);
    `CHK("flags", 8'h03, d)
    u_host.rd(ADDR_FLAGS_ALT, d);
    `CHK("flags alt", 8'h03, d)
    u_host.rd(ADDR_CTRL_ALT, d);
    `CHK("ctrl", 8'h40, d)
    u_host.rd(5'h05, d);
    `CHK("unmapped", 8'h00, d)
    `CHK("halted", 1'b1, halted)
    `CHK("irq idle", 1'b1, irq_pin)
    $display("test reset done");
  endtask

  task automatic t_flags();
    u_host.wr(ADDR_FLAGS, 8'hFF);
    u_host.rd(ADDR_FLAGS, d);
    `CHK("flags one", 8'h03, d)
    u_host.wr(ADDR_FLAGS, 8'h00);
    u_host.rd(ADDR_FLAGS, d);
    `CHK("flags zero", 8'h00, d)
    `CHK("halted", 1'b0, halted)
    pulse(3'b111);
    `CHK("irq disabled", 1'b1, irq_pin)
    u_host.rd(ADDR_FLAGS, d);
    `CHK("events", 8'h38, d)
    u_host.wr(ADDR_FLAGS, 8'h00);
    $display("test flags done");
  endtask

  task automatic t_irq();
    logic [2:0] src[2] = '{3'b100, 3'b010};
    foreach (src[i]) begin
      u_host.wr(ADDR_CTRL, 8'h78);
      pulse(src[i]);
      `CHK("irq pulled", 1'b0, irq_pin)
      u_host.wr(ADDR_FLAGS, 8'h00);
      wait_cyc(15);
      `CHK("irq held", 1'b0, irq_pin)
      wait_cyc(5);
      `CHK("irq released", 1'b1, irq_pin)
    end
    pulse(3'b100);
    u_host.wr(ADDR_CTRL, 8'h58);
    `CHK("enable off", 1'b1, irq_pin)
    pulse(3'b011);
    wait_cyc(25);
    `CHK("alarm held", 1'b0, irq_pin)
    u_host.wr(ADDR_FLAGS, 8'h00);
    `CHK("alarm released", 1'b1, irq_pin)
    u_host.wr(ADDR_CTRL, 8'h40);
    $display("test irq done");
  endtask

  task automatic t_divider();
    u_host.wr(ADDR_CTRL, 8'h41);
    u_host.cond(1'b0);
    u_host.rd(ADDR_CTRL, d);
    `CHK("armed", 8'h41, d)
    u_host.cond(1'b1);
    gap(2, n);
    `CHK("clear soon", 1'b1, n <= 2)
    @(negedge i_mclk);
    gap(1, n);
    `CHK("second gap", 1'b1, n >= 18 && n <= 20)
    u_host.rd(ADDR_CTRL, d);
    `CHK("self clear", 8'h40, d)
    $display("test divider done");
  endtask

  task automatic t_supply();
    int exp_gap[4] = '{10, 40, 200, 600};
    hold = 1'b1;
    wait_cyc(10);
    hold = 1'b0;
    u_host.rd(ADDR_FLAGS, d);
    `CHK("vlow supply", 1'b1, d[FLG_VLOW])
    u_host.reinit();
    osc = 1'b1;
    wait_cyc(40);
    osc = 1'b0;
    u_host.rd(ADDR_FLAGS, d);
    `CHK("vlow osc", 1'b1, d[FLG_VLOW])
    u_host.reinit();
    for (int k = 0; k < 4; k++) begin
      u_host.wr(ADDR_CTRL, {2'(k), 6'h00});
      gap(0, n);
      @(negedge i_mclk);
      gap(0, n);
      `CHK("interval", exp_gap[k], n + 1)
    end
    comp = 1'b1;
    @(negedge i_mclk);
    gap(0, n);
    wait_cyc(2);
    comp = 1'b0;
    u_host.rd(ADDR_FLAGS, d);
    `CHK("vcomp", 8'h01, d)
    `CHK("halted", 1'b1, halted)
    $display("test supply done");
  endtask

  initial begin
    // inputs idle and reset asserted from time zero
    i_mclk = 1'b0;
    i_rst_n = 1'b0;
    evt = 3'b000;
    hold = 1'b0;
    comp = 1'b0;
    osc = 1'b0;
    repeat (5) @(posedge i_mclk);
    @(negedge i_mclk);
    i_rst_n = 1'b1;
    t_reset();
    t_flags();
    t_irq();
    t_divider();
    t_supply();
    tally_and_finish();
  end
endmodule
